// ---- shared/fault_conf_pkg.sv ----
package fault_conf_pkg;
    localparam logic [7:0]  MODULE_CONFIG_OFS  = 8'h00;
    localparam logic [7:0]  ERROR_STATUS_OFS   = 8'h04;
    localparam logic [7:0]  TX_ERR_OFS         = 8'h08;
    localparam logic [7:0]  RX_ERR_OFS         = 8'h0C;
    localparam int          LOW_POWER_REQ_BIT  = 0;
    localparam int          FREEZE_EN_BIT      = 1;
    localparam int          SUSPEND_REQ_BIT    = 2;
    localparam int          SOFT_RESET_BIT     = 3;
    localparam int          WAKE_ON_BUS_BIT    = 4;
    localparam int          WAKE_MASK_BIT      = 5;
    localparam int          NOT_SYNCED_BIT     = 8;
    localparam int          FREEZE_ACK_BIT     = 9;
    localparam int          LP_ACK_BIT         = 10;
    localparam int          FAULT_LSB          = 0;
    localparam int          WAKE_FLAG_BIT      = 2;
    localparam logic        FREEZE_EN_RST      = 1'b1;
    localparam logic        SUSPEND_REQ_RST    = 1'b1;
    localparam logic [7:0]  ERR_CNT_RST        = 8'h00;
    localparam logic [7:0]  ERR_STEP_BIG       = 8'h08;
    localparam logic [7:0]  ERR_BIG_LIMIT      = 8'hF7;
    localparam logic [7:0]  ERR_CNT_MAX        = 8'hFF;
    localparam logic [7:0]  PASSIVE_LEVEL      = 8'h80;
    localparam logic [7:0]  RX_PRESET          = 8'h77;
    localparam logic [3:0]  RECESSIVE_RUN      = 4'hB;
    typedef enum logic [1:0] {
        FS_ACTIVE  = 2'b00,
        FS_PASSIVE = 2'b01,
        FS_BUSOFF  = 2'b10
    } fault_type;
    typedef enum logic [2:0] {
        M_RUN       = 3'b000,
        M_RESYNC    = 3'b001,
        M_FRZ_WAIT  = 3'b010,
        M_FROZEN    = 3'b011,
        M_STOP_WAIT = 3'b100,
        M_STOPPED   = 3'b101
    } mode_type;
endpackage : fault_conf_pkg

// ---- shared/err_cnt_if.sv ----
`timescale 1ns/100ps
interface err_cnt_if;
    logic       inc_big;
    logic       inc_one;
    logic       dec;
    logic       clr;
    logic       load_en;
    logic [7:0] load_val;
    logic [7:0] count;
    logic       ovf;
    modport ctl (output inc_big, inc_one, dec, clr, load_en, load_val, input count, ovf);
    modport cnt (input inc_big, inc_one, dec, clr, load_en, load_val, output count, ovf);
endinterface : err_cnt_if

// ---- logic/err_counter.sv ----
`timescale 1ns/100ps
module err_counter
    import fault_conf_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    err_cnt_if.cnt   port_i
);
    assign port_i.ovf = port_i.inc_big && (port_i.count > ERR_BIG_LIMIT);

    always_ff @(posedge mclk) begin
        if (rst || port_i.clr) begin
            port_i.count <= ERR_CNT_RST;
        end else if (port_i.load_en) begin
            port_i.count <= port_i.load_val;
        end else if (port_i.inc_big) begin
            if (port_i.count > ERR_BIG_LIMIT) begin
                port_i.count <= ERR_CNT_MAX;
            end else begin
                port_i.count <= port_i.count + ERR_STEP_BIG;
            end
        end else if (port_i.inc_one) begin
            if (port_i.count != ERR_CNT_MAX) begin
                port_i.count <= port_i.count + 8'h01;
            end
        end else if (port_i.dec && port_i.count != 8'h00) begin
            port_i.count <= port_i.count - 8'h01;
        end
    end
endmodule : err_counter

// ---- logic/fault_confinement.sv ----
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
// Overview of operation
// - Two 8-bit error counters, up by 8 or 1, down by 1, floor zero.
// - Receive counter above 127 stops rising; good reception presets it to 119.
// - Software may write counters only while frozen or suspended.
// - Any counter at 128 or more makes the node error-passive.
// - Both counters at 127 or less return the node to error-active.
// - Transmit counter passing 255 means bus-off; counter then clears.
// - Bus-off counts runs of 11 recessive bits into the transmit counter.
// - Dominant bit in a short run clears only the run counter.
// - Bus-off drives nothing; passive sends passive flags, delays transmit.
// - Debug requested by suspend bit or breakpoint, only with freeze enable.
// - Debug entry waits for idle, intermission or fault, then quiet engine.
// - Frozen: frames stop, prescaler off, rx ignored, tx recessive, flags set.
// - Debug exit on released request, then wait 11 recessive bits.
// - Stop entry waits for idle or recessive third intermission bit, quiet engine.
// - Stop ends on reset, soft reset or cleared low-power request.
// - Armed wake: bus edge clears request, wakes, receives frame without arbitration.
// - Bus edge during stop sets wake flag; interrupt only if masked in.
// - Stop in bus-off pauses recovery counting until request clears.
// - Stop requested while frozen first resynchronises, then awaits stop entry.
// - Immediate wake edge may clear request without ever acknowledging stop.
// - Clearing freeze enable leaves debug and ignores debug requests.
module fault_confinement
    import fault_conf_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        srst,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    input  wire logic        can_rx_pin,
    output logic             can_tx_pin,
    input  wire logic        breakpoint_in,
    input  wire logic        bit_tick,
    input  wire logic        tx_bit,
    input  wire logic        tx_err_big,
    input  wire logic        tx_ok,
    input  wire logic        rx_err_big,
    input  wire logic        rx_err_one,
    input  wire logic        rx_ok,
    input  wire logic        bus_idle,
    input  wire logic        bus_intermission,
    input  wire logic        third_ifs_recessive,
    input  wire logic        engine_busy,
    output logic             frame_enable,
    output logic             prescaler_enable,
    output logic             clock_enable,
    output logic             passive_flags,
    output logic             tx_start_delay,
    output logic             wake_sof,
    output logic             bus_off_event,
    output logic             wake_irq
);
    err_cnt_if tx_if ();
    err_cnt_if rx_if ();

    logic       rst_all;
    logic       low_power_req_r;
    logic       freeze_enable_r;
    logic       suspend_req_r;
    logic       soft_reset_r;
    logic       wake_on_bus_enable_r;
    logic       wake_irq_mask_r;
    logic       wake_event_flag_r;
    logic       wake_armed_r;
    logic       rx_meta_r;
    logic       rx_sync_r;
    logic       rx_prev_r;
    logic       breakpoint_in_meta_r;
    logic       breakpoint_in_sync_r;
    logic [3:0] rec_cnt_r;
    mode_type   mode_r;
    fault_type  fault_r;
    fault_type  fault_nxt;
    logic       debug_req;
    logic       wake_edge;
    logic       run_done;
    logic       bus_off;
    logic       recov_done;
    logic       counting_on;
    logic       cnt_wr_ok;
    logic       mcr_wr;
    logic       stop_ready;
    logic       frz_ready;

    assign rst_all     = srst || soft_reset_r;
    assign mcr_wr      = reg_wr && reg_addr == MODULE_CONFIG_OFS;
    assign debug_req   = freeze_enable_r && (suspend_req_r || breakpoint_in_sync_r);
    assign wake_edge   = rx_prev_r && !rx_sync_r;
    assign run_done    = bit_tick && rx_sync_r && rec_cnt_r == RECESSIVE_RUN - 4'h1;
    assign bus_off     = fault_r == FS_BUSOFF;
    assign recov_done  = bus_off && tx_if.count >= PASSIVE_LEVEL;
    assign counting_on = mode_r == M_RUN && !bus_off;
    assign cnt_wr_ok   = mode_r == M_FROZEN || suspend_req_r;
    assign frz_ready   = (bus_idle || bus_intermission || fault_r != FS_ACTIVE)
                         && !engine_busy;
    assign stop_ready  = (bus_idle || third_ifs_recessive) && !engine_busy;

    err_counter u_tx_cnt (
        .mclk   (mclk),
        .rst    (rst_all),
        .port_i (tx_if.cnt)
    );
    err_counter u_rx_cnt (
        .mclk   (mclk),
        .rst    (rst_all),
        .port_i (rx_if.cnt)
    );

    // Error counter steering
    assign tx_if.inc_big  = counting_on && tx_err_big;
    assign tx_if.inc_one  = bus_off && run_done && mode_r != M_STOPPED;
    assign tx_if.dec      = counting_on && tx_ok && !tx_err_big;
    assign tx_if.clr      = tx_if.ovf || recov_done;
    assign tx_if.load_en  = reg_wr && reg_addr == TX_ERR_OFS && cnt_wr_ok;
    assign tx_if.load_val = reg_wdata[7:0];
    assign rx_if.inc_big  = counting_on && rx_err_big && rx_if.count < PASSIVE_LEVEL;
    assign rx_if.inc_one  = counting_on && rx_err_one && rx_if.count < PASSIVE_LEVEL;
    assign rx_if.dec      = counting_on && rx_ok && rx_if.count < PASSIVE_LEVEL;
    assign rx_if.clr      = recov_done;
    always_comb begin
        rx_if.load_en  = 1'b0;
        rx_if.load_val = reg_wdata[7:0];
        if (reg_wr && reg_addr == RX_ERR_OFS && cnt_wr_ok) begin
            rx_if.load_en = 1'b1;
        end else if (counting_on && rx_ok && rx_if.count >= PASSIVE_LEVEL) begin
            rx_if.load_en  = 1'b1;
            rx_if.load_val = RX_PRESET;
        end
    end

    // Fault state
    always_comb begin
        if (bus_off) begin
            fault_nxt = recov_done ? FS_ACTIVE : FS_BUSOFF;
        end else if (tx_if.ovf) begin
            fault_nxt = FS_BUSOFF;
        end else if (tx_if.count >= PASSIVE_LEVEL || rx_if.count >= PASSIVE_LEVEL) begin
            fault_nxt = FS_PASSIVE;
        end else begin
            fault_nxt = FS_ACTIVE;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst_all) begin
            fault_r       <= FS_ACTIVE;
            bus_off_event <= 1'b0;
        end else begin
            fault_r       <= fault_nxt;
            bus_off_event <= !bus_off && fault_nxt == FS_BUSOFF;
        end
    end

    // Pin synchronisers
    always_ff @(posedge mclk) begin
        if (rst_all) begin
            rx_meta_r   <= 1'b1;
            rx_sync_r   <= 1'b1;
            rx_prev_r   <= 1'b1;
            breakpoint_in_meta_r <= 1'b0;
            breakpoint_in_sync_r <= 1'b0;
        end else begin
            rx_meta_r   <= can_rx_pin;
            rx_sync_r   <= rx_meta_r;
            rx_prev_r   <= rx_sync_r;
            breakpoint_in_meta_r <= breakpoint_in;
            breakpoint_in_sync_r <= breakpoint_in_meta_r;
        end
    end

    // Recessive run counter, paused while stopped
    always_ff @(posedge mclk) begin
        if (rst_all) begin
            rec_cnt_r <= 4'h0;
        end else if ((!bus_off && mode_r != M_RESYNC) || mode_r == M_FROZEN) begin
            rec_cnt_r <= 4'h0;
        end else if (bit_tick && mode_r != M_STOPPED) begin
            rec_cnt_r <= (!rx_sync_r || run_done) ? 4'h0 : rec_cnt_r + 4'h1;
        end
    end

    // Mode sequencing
    always_ff @(posedge mclk) begin
        if (rst_all) begin
            mode_r       <= M_FROZEN;
            wake_armed_r <= 1'b0;
        end else begin
            unique case (mode_r)
                M_RUN: begin
                    if (low_power_req_r) begin
                        mode_r <= M_STOP_WAIT;
                    end else if (debug_req) begin
                        mode_r <= M_FRZ_WAIT;
                    end
                end
                M_RESYNC: begin
                    if (debug_req && !low_power_req_r) begin
                        mode_r <= M_FRZ_WAIT;
                    end else if (run_done) begin
                        mode_r <= M_RUN;
                    end
                end
                M_FRZ_WAIT: begin
                    if (!debug_req || low_power_req_r) begin
                        mode_r <= M_RUN;
                    end else if (frz_ready) begin
                        mode_r <= M_FROZEN;
                    end
                end
                M_FROZEN: begin
                    if (!debug_req || low_power_req_r) begin
                        mode_r <= M_RESYNC;
                    end
                end
                M_STOP_WAIT: begin
                    if (!low_power_req_r) begin
                        mode_r <= M_RUN;
                    end else if (stop_ready) begin
                        mode_r       <= M_STOPPED;
                        wake_armed_r <= wake_on_bus_enable_r;
                    end
                end
                M_STOPPED: begin
                    if (wake_armed_r && wake_edge) begin
                        mode_r <= M_RUN;
                    end else if (!low_power_req_r) begin
                        mode_r <= M_RESYNC;
                    end
                end
                default: begin
                    mode_r <= M_FROZEN;
                end
            endcase
        end
    end

    // Wake handling
    always_ff @(posedge mclk) begin
        if (rst_all) begin
            wake_sof          <= 1'b0;
            wake_event_flag_r <= 1'b0;
        end else begin
            wake_sof <= mode_r == M_STOPPED && wake_armed_r && wake_edge;
            if (mode_r == M_STOPPED && wake_edge) begin
                wake_event_flag_r <= 1'b1;
            end else if (reg_wr && reg_addr == ERROR_STATUS_OFS && reg_wdata[WAKE_FLAG_BIT]) begin
                wake_event_flag_r <= 1'b0;
            end
        end
    end
    assign wake_irq = wake_event_flag_r && wake_irq_mask_r;

    // Configuration register
    always_ff @(posedge mclk) begin
        if (rst_all) begin
            low_power_req_r      <= 1'b0;
            freeze_enable_r      <= FREEZE_EN_RST;
            suspend_req_r        <= SUSPEND_REQ_RST;
            soft_reset_r         <= 1'b0;
            wake_on_bus_enable_r <= 1'b0;
            wake_irq_mask_r      <= 1'b0;
        end else begin
            if (mcr_wr) begin
                freeze_enable_r      <= reg_wdata[FREEZE_EN_BIT];
                suspend_req_r        <= reg_wdata[SUSPEND_REQ_BIT];
                soft_reset_r         <= reg_wdata[SOFT_RESET_BIT];
                wake_on_bus_enable_r <= reg_wdata[WAKE_ON_BUS_BIT];
                wake_irq_mask_r      <= reg_wdata[WAKE_MASK_BIT];
            end
            if (wake_edge && ((mode_r == M_STOPPED && wake_armed_r)
                || (mode_r == M_STOP_WAIT && wake_on_bus_enable_r))) begin
                low_power_req_r <= 1'b0;
            end else if (mcr_wr) begin
                low_power_req_r <= reg_wdata[LOW_POWER_REQ_BIT];
            end
        end
    end

    // Read port
    always_ff @(posedge mclk) begin
        if (rst_all) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            unique case (reg_addr)
                MODULE_CONFIG_OFS: begin
                    reg_rdata <= 16'h0000;
                    reg_rdata[LOW_POWER_REQ_BIT] <= low_power_req_r;
                    reg_rdata[FREEZE_EN_BIT]     <= freeze_enable_r;
                    reg_rdata[SUSPEND_REQ_BIT]   <= suspend_req_r;
                    reg_rdata[WAKE_ON_BUS_BIT]   <= wake_on_bus_enable_r;
                    reg_rdata[WAKE_MASK_BIT]     <= wake_irq_mask_r;
                    reg_rdata[NOT_SYNCED_BIT]    <= mode_r != M_RUN && mode_r != M_FRZ_WAIT
                                                    && mode_r != M_STOP_WAIT;
                    reg_rdata[FREEZE_ACK_BIT]    <= mode_r == M_FROZEN;
                    reg_rdata[LP_ACK_BIT]        <= mode_r == M_STOPPED;
                end
                ERROR_STATUS_OFS: begin
                    reg_rdata <= {13'h0000, wake_event_flag_r, fault_r};
                end
                TX_ERR_OFS: begin
                    reg_rdata <= {8'h00, tx_if.count};
                end
                RX_ERR_OFS: begin
                    reg_rdata <= {8'h00, rx_if.count};
                end
                default: begin
                    reg_rdata <= 16'h0000;
                end
            endcase
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    // Bus side controls
    assign frame_enable     = counting_on;
    assign prescaler_enable = mode_r != M_FROZEN && mode_r != M_STOPPED;
    assign clock_enable     = mode_r != M_STOPPED;
    assign passive_flags    = fault_r == FS_PASSIVE;
    assign tx_start_delay   = fault_r == FS_PASSIVE;

    always_ff @(posedge mclk) begin
        if (rst_all) begin
            can_tx_pin <= 1'b1;
        end else begin
            can_tx_pin <= counting_on ? tx_bit : 1'b1;
        end
    end

    a_busoff_entry: assert property (@(posedge mclk) disable iff (rst_all)
        (!bus_off && tx_if.ovf) |=> (fault_r == FS_BUSOFF && tx_if.count == 8'h00))
        else $error("bus-off not entered on overflow");
    a_busoff_quiet: assert property (@(posedge mclk) disable iff (rst_all)
        (bus_off && $past(bus_off)) |-> can_tx_pin)
        else $error("transmit driven during bus-off");
    a_passive_entry: assert property (@(posedge mclk) disable iff (rst_all)
        (!bus_off && !tx_if.ovf && tx_if.count >= PASSIVE_LEVEL) |=> fault_r == FS_PASSIVE)
        else $error("passive state missed");
    a_rx_saturate: assert property (@(posedge mclk) disable iff (rst_all)
        (rx_if.count >= PASSIVE_LEVEL && !rx_ok && !reg_wr && !recov_done)
        |=> rx_if.count == $past(rx_if.count))
        else $error("receive counter moved above 127");
    a_recov_step: assert property (@(posedge mclk) disable iff (rst_all)
        (bus_off && run_done && mode_r != M_STOPPED && !recov_done && !reg_wr)
        |=> tx_if.count == $past(tx_if.count) + 8'h01)
        else $error("recovery step lost");
    a_recov_dominant: assert property (@(posedge mclk) disable iff (rst_all)
        (bus_off && bit_tick && !rx_sync_r && mode_r != M_STOPPED && !reg_wr && !recov_done)
        |=> (rec_cnt_r == 4'h0 && $stable(tx_if.count)))
        else $error("dominant bit disturbed recovery");
    a_freeze_gate: assert property (@(posedge mclk) disable iff (rst_all)
        (mode_r == M_FRZ_WAIT && !freeze_enable_r) |=> mode_r == M_RUN)
        else $error("debug entry without freeze enable");
    a_wake_flag: assert property (@(posedge mclk) disable iff (rst_all)
        (mode_r == M_STOPPED && wake_edge) |=> wake_event_flag_r ##1 wake_event_flag_r
        || !$past(reg_wr))
        else $error("wake flag not set");
    a_stop_pause: assert property (@(posedge mclk) disable iff (rst_all)
        (mode_r == M_STOPPED && $past(mode_r) == M_STOPPED) |-> $stable(rec_cnt_r))
        else $error("recovery count ran during stop");
endmodule : fault_confinement

// ---- test/can_bus_model.sv ----
`timescale 1ns/100ps
module can_bus_model (
    input  wire logic mclk,
    input  wire logic srst,
    input  wire logic tick_en,
    input  wire logic tx_pin,
    input  wire logic dom_req,
    output logic      rx_pin,
    output logic      bit_tick
);
    logic [1:0] div_r;
    // Wired-and bus: any dominant driver wins, released bus floats recessive
    assign rx_pin = tx_pin & ~dom_req;
    // Bit sample pulse every fourth clock, halted with the prescaler
    always_ff @(posedge mclk) begin
        if (srst || !tick_en) div_r <= 2'h0;
        else div_r <= div_r + 2'h1;
    end
    assign bit_tick = tick_en && (div_r == 2'h3);
endmodule : can_bus_model

// ---- test/can_fault_confinement_modes_tb.sv ----
`timescale 1ns/100ps
module can_fault_confinement_modes_tb;
    import fault_conf_pkg::*;
    logic        mclk, srst, reg_wr, reg_rd, can_rx_pin, can_tx_pin, breakpoint_in;
    logic        bit_tick, bus_idle, dom, frame_enable, prescaler_enable, clock_enable;
    logic        passive_flags, tx_start_delay, wake_sof, bus_off_event, wake_irq;
    logic [7:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata, rd_q;
    logic        tx_drive, busy, ifs;
    logic [4:0]  ev;
    logic        boe_seen = 1'b0;
    logic        sof_seen = 1'b0;
    int          num_errors = 0;
    int          n_checks = 0;
    fault_confinement u_fault_confinement (.mclk(mclk), .srst(srst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .can_rx_pin(can_rx_pin), .can_tx_pin(can_tx_pin), .breakpoint_in(breakpoint_in),
        .bit_tick(bit_tick), .tx_bit(tx_drive), .tx_err_big(ev[0]), .tx_ok(ev[1]),
        .rx_err_big(ev[2]), .rx_err_one(ev[3]), .rx_ok(ev[4]), .bus_idle(bus_idle),
        .bus_intermission(ifs), .third_ifs_recessive(ifs), .engine_busy(busy),
        .frame_enable(frame_enable), .prescaler_enable(prescaler_enable),
        .clock_enable(clock_enable), .passive_flags(passive_flags),
        .tx_start_delay(tx_start_delay), .wake_sof(wake_sof),
        .bus_off_event(bus_off_event), .wake_irq(wake_irq));
    can_bus_model u_can_bus_model (.mclk(mclk), .srst(srst), .tick_en(prescaler_enable),
        .tx_pin(can_tx_pin), .dom_req(dom), .rx_pin(can_rx_pin), .bit_tick(bit_tick));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // Sticky capture of one-cycle pulses
    always @(posedge mclk) begin
        if (bus_off_event === 1'b1) boe_seen <= 1'b1;
        if (wake_sof === 1'b1) sof_seen <= 1'b1;
    end
    task end_sim;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : end_sim
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(posedge mclk);
        rd_q = reg_rdata;
    endtask : rd
    task pulse(input int i, input int n);
        repeat (n) begin
            @(posedge mclk);
            ev[i] <= 1'b1;
            @(posedge mclk);
            ev[i] <= 1'b0;
        end
        repeat (3) @(posedge mclk);
    endtask : pulse
    task poll(input logic [7:0] a, input int b, input logic v);
        int k;
        k = 0;
        rd(a);
        while (rd_q[b] !== v && k < 3000) begin
            rd(a);
            k++;
        end
        chk(rd_q[b], v);
    endtask : poll
    task t_reset;
        rd(MODULE_CONFIG_OFS);
        chk(rd_q, 16'h0306);
        rd(ERROR_STATUS_OFS);
        chk(rd_q, 16'h0000);
        rd(TX_ERR_OFS);
        chk(rd_q, 16'h0000);
        rd(8'h10);
        chk(rd_q, 16'h0000);
        $display("t_reset done");
    endtask : t_reset
    task t_tx;
        wr(TX_ERR_OFS, 16'h007F);
        rd(TX_ERR_OFS);
        chk(rd_q, 16'h007F);
        wr(MODULE_CONFIG_OFS, 16'h0002);
        poll(MODULE_CONFIG_OFS, NOT_SYNCED_BIT, 1'b0);
        wr(TX_ERR_OFS, 16'h0010);
        rd(TX_ERR_OFS);
        chk(rd_q, 16'h007F);
        pulse(0, 1);
        rd(TX_ERR_OFS);
        chk(rd_q, 16'h0087);
        rd(ERROR_STATUS_OFS);
        chk(rd_q, 16'h0001);
        chk({passive_flags, tx_start_delay}, 16'h0003);
        pulse(1, 8);
        rd(ERROR_STATUS_OFS);
        chk(rd_q, 16'h0000);
        tx_drive <= 1'b0;
        pulse(0, 17);
        rd(TX_ERR_OFS);
        chk(rd_q, 16'h0000);
        rd(ERROR_STATUS_OFS);
        chk({rd_q[1:0], boe_seen, can_tx_pin, frame_enable}, 16'h0016);
        $display("t_tx done");
    endtask : t_tx
    task t_recover;
        dom <= 1'b1;
        repeat (8) @(posedge mclk);
        dom <= 1'b0;
        repeat (36) @(posedge mclk);
        dom <= 1'b1;
        repeat (8) @(posedge mclk);
        dom <= 1'b0;
        repeat (36) @(posedge mclk);
        rd(TX_ERR_OFS);
        chk(rd_q, 16'h0000);
        repeat (24) @(posedge mclk);
        rd(TX_ERR_OFS);
        chk(rd_q, 16'h0001);
        poll(ERROR_STATUS_OFS, 1, 1'b0);
        rd(TX_ERR_OFS);
        chk(rd_q, 16'h0000);
        $display("t_recover done");
    endtask : t_recover
    task t_rx;
        pulse(3, 1);
        rd(RX_ERR_OFS);
        chk(rd_q, 16'h0001);
        pulse(2, 16);
        rd(ERROR_STATUS_OFS);
        chk(rd_q, 16'h0001);
        pulse(3, 1);
        rd(RX_ERR_OFS);
        chk(rd_q, 16'h0081);
        pulse(4, 1);
        rd(RX_ERR_OFS);
        chk(rd_q, 16'h0077);
        rd(ERROR_STATUS_OFS);
        chk(rd_q, 16'h0000);
        $display("t_rx done");
    endtask : t_rx
    task t_debug;
        wr(MODULE_CONFIG_OFS, 16'h0004);
        breakpoint_in <= 1'b1;
        repeat (20) @(posedge mclk);
        rd(MODULE_CONFIG_OFS);
        chk(rd_q[FREEZE_ACK_BIT], 1'b0);
        bus_idle <= 1'b0;
        busy <= 1'b1;
        wr(MODULE_CONFIG_OFS, 16'h0002);
        wr(MODULE_CONFIG_OFS, 16'h0000);
        wr(MODULE_CONFIG_OFS, 16'h0002);
        repeat (20) @(posedge mclk);
        rd(MODULE_CONFIG_OFS);
        chk(rd_q[FREEZE_ACK_BIT], 1'b0);
        ifs <= 1'b1;
        repeat (20) @(posedge mclk);
        rd(MODULE_CONFIG_OFS);
        chk(rd_q[FREEZE_ACK_BIT], 1'b0);
        busy <= 1'b0;
        poll(MODULE_CONFIG_OFS, FREEZE_ACK_BIT, 1'b1);
        chk({prescaler_enable, frame_enable, can_tx_pin}, 16'h0001);
        wr(RX_ERR_OFS, 16'h0005);
        rd(RX_ERR_OFS);
        chk(rd_q, 16'h0005);
        breakpoint_in <= 1'b0;
        poll(MODULE_CONFIG_OFS, NOT_SYNCED_BIT, 1'b0);
        tx_drive <= 1'b1;
        $display("t_debug done");
    endtask : t_debug
    task t_stop;
        wr(MODULE_CONFIG_OFS, 16'h0003);
        poll(MODULE_CONFIG_OFS, LP_ACK_BIT, 1'b1);
        wr(MODULE_CONFIG_OFS, 16'h0002);
        poll(MODULE_CONFIG_OFS, LP_ACK_BIT, 1'b0);
        wr(MODULE_CONFIG_OFS, 16'h0033);
        poll(MODULE_CONFIG_OFS, LP_ACK_BIT, 1'b1);
        chk({clock_enable, wake_irq, can_tx_pin}, 16'h0001);
        dom <= 1'b1;
        repeat (10) @(posedge mclk);
        dom <= 1'b0;
        rd(MODULE_CONFIG_OFS);
        chk({sof_seen, rd_q[LOW_POWER_REQ_BIT]}, 16'h0002);
        rd(ERROR_STATUS_OFS);
        chk({rd_q[WAKE_FLAG_BIT], wake_irq}, 16'h0003);
        wr(ERROR_STATUS_OFS, 16'h0004);
        rd(ERROR_STATUS_OFS);
        chk(rd_q[WAKE_FLAG_BIT], 1'b0);
        wr(MODULE_CONFIG_OFS, 16'h0003);
        poll(MODULE_CONFIG_OFS, LP_ACK_BIT, 1'b1);
        wr(MODULE_CONFIG_OFS, 16'h000B);
        rd(MODULE_CONFIG_OFS);
        chk(rd_q, 16'h0306);
        rd(RX_ERR_OFS);
        chk(rd_q, 16'h0000);
        $display("t_stop done");
    endtask : t_stop
    initial begin
        repeat (40000) @(posedge mclk);
        num_errors++;
        end_sim;
    end
    initial begin
        srst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        ev = 5'h00;
        bus_idle = 1'b1;
        dom = 1'b0;
        tx_drive = 1'b1;
        busy = 1'b0;
        ifs = 1'b0;
        breakpoint_in = 1'b0;
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        t_reset;
        t_tx;
        t_recover;
        t_rx;
        t_debug;
        t_stop;
        end_sim;
    end
endmodule : can_fault_confinement_modes_tb
